// File: node_irq_pkg.sv
package node_irq_pkg;

  // ----------------------------------------------------------------------
  // Register indices on the node register port (choices, see note)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_PEND    = 8'h00;
  localparam logic [7:0] ADDR_MASTER_PEND = 8'h01;
  localparam logic [7:0] ADDR_LINK_MASK   = 8'h02;
  localparam logic [7:0] ADDR_PIN_MASK    = 8'h03;
  localparam logic [7:0] ADDR_MASTER_MASK = 8'h04;
  localparam logic [7:0] ADDR_ERR_CTRL    = 8'h05;
  localparam logic [7:0] ADDR_ERR_TALLY   = 8'h06;
  localparam logic [7:0] ADDR_TEST_CTRL   = 8'h07;
  localparam logic [7:0] ADDR_PRBS_B0     = 8'h08;
  localparam logic [7:0] ADDR_PRBS_B1     = 8'h09;
  localparam logic [7:0] ADDR_PRBS_B2     = 8'h0a;
  localparam logic [7:0] ADDR_PRBS_B3     = 8'h0b;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PIN0_BIT        = 0;
  localparam int PIN1_BIT        = 1;
  localparam int NEW_NODE_BIT    = 0;
  localparam int I2C_FAULT_BIT   = 1;
  localparam int IRQ_CRC_BIT     = 2;
  localparam int SLAVE_SIG_BIT   = 3;
  localparam int LEVEL_LSB       = 5;
  localparam int CNT_IRQ_CRC_BIT = 4;
  localparam int CNT_PARITY_BIT  = 3;
  localparam int CNT_CRC_BIT     = 2;
  localparam int CNT_DECODE_BIT  = 1;
  localparam int CNT_HEADER_BIT  = 0;
  localparam int PRBS_UP_BIT     = 0;
  localparam int PRBS_DN_BIT     = 1;
  localparam int HOP_BIT         = 2;
  localparam int FIFO_LSB        = 4;

  // Master pending and mask registers use only bits 3:0
  localparam logic [7:0] MASTER_BITS = 8'h0f;
  localparam logic [7:0] TEST_BITS   = 8'h37;
  localparam logic [7:0] RESET_VAL   = 8'h00;

endpackage : node_irq_pkg

// File: node_irq_error_counting.sv
`timescale 1ns/100ps
module node_irq_error_counting #(
  parameter int TALLY_W = 8,
  parameter int PRBS_W  = 32
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Node role strap: high in a master node
  input  wire logic       i_is_master,
  // Register port
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Event strobes, one cycle each
  input  wire logic       i_pin0_event,
  input  wire logic       i_pin1_event,
  input  wire logic       i_slave_signal,
  input  wire logic       i_irq_frame_crc,
  input  wire logic       i_i2c_fault,
  input  wire logic       i_new_node,
  input  wire logic       i_parity_err,
  input  wire logic       i_frame_crc_err,
  input  wire logic       i_decode_err,
  input  wire logic       i_header_err,
  input  wire logic       i_prbs_mismatch,
  // Link-error pending bits kept elsewhere
  input  wire logic [7:0] i_link_err_pending,
  // Outputs
  output logic            o_irq,
  output logic            o_tally_overflow,
  output logic            o_prbs_down,
  output logic            o_prbs_up,
  output logic            o_hop_check,
  output logic      [1:0] o_fifo_extra
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire logic wr_pin_pend  = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_PIN_PEND;
  wire logic wr_mst_pend  = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_MASTER_PEND;
  wire logic wr_link_mask = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_LINK_MASK;
  wire logic wr_pin_mask  = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_PIN_MASK;
  wire logic wr_mst_mask  = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_MASTER_MASK;
  wire logic wr_err_ctrl  = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_ERR_CTRL;
  wire logic wr_tally     = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_ERR_TALLY;
  wire logic wr_test      = i_reg_wr &&
                            i_reg_addr == node_irq_pkg::ADDR_TEST_CTRL;

  logic [7:0] pin_pend_q, mst_pend_q, link_mask_q, pin_mask_q;
  logic [7:0] mst_mask_q, err_ctrl_q, test_q;
  logic [7:0] pin_pend_d, mst_pend_d;
  logic [TALLY_W-1:0] tally_q, tally_d;
  logic [PRBS_W-1:0]  prbs_q;
  logic               ovf_q;

  // ----------------------------------------------------------------------
  // Pending sets; a set in the clear cycle wins
  // ----------------------------------------------------------------------
  logic [7:0] pin_set, mst_set, pin_clr, mst_clr;
  always_comb begin
    pin_set = 8'h00;
    pin_set[node_irq_pkg::PIN1_BIT] = i_pin1_event;
    pin_set[node_irq_pkg::PIN0_BIT] = i_pin0_event && !i_is_master;
    mst_set = 8'h00;
    mst_set[node_irq_pkg::SLAVE_SIG_BIT] = i_slave_signal;
    mst_set[node_irq_pkg::IRQ_CRC_BIT]   = i_irq_frame_crc;
    mst_set[node_irq_pkg::I2C_FAULT_BIT] = i_i2c_fault;
    mst_set[node_irq_pkg::NEW_NODE_BIT]  = i_new_node;
    mst_set = i_is_master ? mst_set : 8'h00;
    pin_clr = wr_pin_pend ? i_reg_wdata : 8'h00;
    mst_clr = wr_mst_pend ? i_reg_wdata : 8'h00;
    pin_pend_d = (pin_pend_q & ~pin_clr) | pin_set;
    mst_pend_d = ((mst_pend_q & ~mst_clr) | mst_set) &
                 node_irq_pkg::MASTER_BITS;
  end

  // Read view forces master-only and slave-only bits to zero
  wire logic [7:0] pin_pend_view = i_is_master ?
    (pin_pend_q & ~(8'h01 << node_irq_pkg::PIN0_BIT)) : pin_pend_q;
  wire logic [7:0] mst_pend_view = i_is_master ? mst_pend_q : 8'h00;

  // ----------------------------------------------------------------------
  // Bit error tally
  // ----------------------------------------------------------------------
  wire logic count_hit =
    (err_ctrl_q[node_irq_pkg::CNT_IRQ_CRC_BIT] && i_irq_frame_crc) ||
    (err_ctrl_q[node_irq_pkg::CNT_PARITY_BIT]  && i_parity_err)    ||
    (err_ctrl_q[node_irq_pkg::CNT_CRC_BIT]     && i_frame_crc_err) ||
    (err_ctrl_q[node_irq_pkg::CNT_DECODE_BIT]  && i_decode_err)    ||
    (err_ctrl_q[node_irq_pkg::CNT_HEADER_BIT]  && i_header_err);

  wire logic [2:0] level = err_ctrl_q[node_irq_pkg::LEVEL_LSB +: 3];
  // Overflow point is 2^(level+1); 9 bits so that 256 is representable
  wire logic [8:0] limit = 9'h002 << level;
  wire logic [8:0] tally_next = {1'b0, tally_q} + 9'h001;

  always_comb begin
    tally_d = tally_q;
    if (wr_tally) begin
      tally_d = '0;
    end else if (count_hit && tally_q != '1) begin
      tally_d = tally_next[TALLY_W-1:0];
    end
  end

  // Overflow flag raised when the count reaches the selected point
  wire logic ovf_set = count_hit && !wr_tally &&
                       (tally_next == limit);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_pend_q  <= node_irq_pkg::RESET_VAL;
      mst_pend_q  <= node_irq_pkg::RESET_VAL;
      link_mask_q <= node_irq_pkg::RESET_VAL;
      pin_mask_q  <= node_irq_pkg::RESET_VAL;
      mst_mask_q  <= node_irq_pkg::RESET_VAL;
      err_ctrl_q  <= node_irq_pkg::RESET_VAL;
      test_q      <= node_irq_pkg::RESET_VAL;
      tally_q     <= '0;
      ovf_q       <= 1'b0;
    end else begin
      pin_pend_q  <= pin_pend_d;
      mst_pend_q  <= mst_pend_d;
      if (wr_link_mask) link_mask_q <= i_reg_wdata;
      if (wr_pin_mask)  pin_mask_q  <= i_reg_wdata;
      if (wr_mst_mask)  mst_mask_q  <= i_reg_wdata &
                                       node_irq_pkg::MASTER_BITS;
      if (wr_err_ctrl)  err_ctrl_q  <= i_reg_wdata;
      if (wr_test)      test_q      <= i_reg_wdata &
                                       node_irq_pkg::TEST_BITS;
      tally_q <= tally_d;
      // Tally write clears it and wins over a set in the same cycle
      ovf_q   <= ovf_set || (ovf_q && !wr_tally);
    end
  end

  // ----------------------------------------------------------------------
  // PRBS mismatch tally, counts only while a direction is enabled
  // ----------------------------------------------------------------------
  wire logic prbs_on = test_q[node_irq_pkg::PRBS_DN_BIT] ||
                       test_q[node_irq_pkg::PRBS_UP_BIT];
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prbs_q <= '0;
    end else if (prbs_on && i_prbs_mismatch && prbs_q != '1) begin
      prbs_q <= prbs_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Test controls toward the link logic
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_prbs_down  <= 1'b0;
      o_prbs_up    <= 1'b0;
      o_hop_check  <= 1'b0;
      o_fifo_extra <= 2'b00;
    end else begin
      o_prbs_down  <= test_q[node_irq_pkg::PRBS_DN_BIT];
      o_prbs_up    <= test_q[node_irq_pkg::PRBS_UP_BIT];
      o_hop_check  <= test_q[node_irq_pkg::HOP_BIT] && prbs_on;
      // Codes 2 and 3 both add two entries
      o_fifo_extra <= (test_q[node_irq_pkg::FIFO_LSB +: 2] == 2'b11) ?
                      2'b10 : test_q[node_irq_pkg::FIFO_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request and overflow
  // ----------------------------------------------------------------------
  // Overflow surfaces as link-error bit 5 alongside the outside bits
  wire logic [7:0] link_pend = i_link_err_pending |
                               {2'b00, ovf_q, 5'b00000};
  assign o_irq = |(link_pend & link_mask_q) |
                 |(pin_pend_view & pin_mask_q) |
                 |(mst_pend_view & mst_mask_q);
  assign o_tally_overflow = ovf_q;

  // ----------------------------------------------------------------------
  // Read data, registered
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    if (i_reg_addr == node_irq_pkg::ADDR_PIN_PEND) begin
      rd_mux = pin_pend_view;
    end else if (i_reg_addr == node_irq_pkg::ADDR_MASTER_PEND) begin
      rd_mux = mst_pend_view;
    end else if (i_reg_addr == node_irq_pkg::ADDR_LINK_MASK) begin
      rd_mux = link_mask_q;
    end else if (i_reg_addr == node_irq_pkg::ADDR_PIN_MASK) begin
      rd_mux = pin_mask_q;
    end else if (i_reg_addr == node_irq_pkg::ADDR_MASTER_MASK) begin
      rd_mux = mst_mask_q;
    end else if (i_reg_addr == node_irq_pkg::ADDR_ERR_CTRL) begin
      rd_mux = err_ctrl_q;
    end else if (i_reg_addr == node_irq_pkg::ADDR_ERR_TALLY) begin
      rd_mux = tally_q[7:0];
    end else if (i_reg_addr == node_irq_pkg::ADDR_TEST_CTRL) begin
      rd_mux = test_q;
    end else if (i_reg_addr == node_irq_pkg::ADDR_PRBS_B0) begin
      rd_mux = prbs_q[7:0];
    end else if (i_reg_addr == node_irq_pkg::ADDR_PRBS_B1) begin
      rd_mux = prbs_q[15:8];
    end else if (i_reg_addr == node_irq_pkg::ADDR_PRBS_B2) begin
      rd_mux = prbs_q[23:16];
    end else if (i_reg_addr == node_irq_pkg::ADDR_PRBS_B3) begin
      rd_mux = prbs_q[31:24];
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

endmodule : node_irq_error_counting

// File: node_irq_error_counting_checker.sv
`timescale 1ns/100ps
// Port-level watcher for register answers and test controls
module node_irq_error_counting_checker #(
  parameter int TALLY_W = 8,
  parameter int PRBS_W  = 32
) (
  // Clock, reset and register port
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_is_master,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Control outputs
  input wire logic       o_tally_overflow,
  input wire logic       o_prbs_down,
  input wire logic       o_prbs_up,
  input wire logic       o_hop_check,
  input wire logic [1:0] o_fifo_extra
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Decoded accesses
  wire logic t_wr = i_reg_wr && i_reg_addr == node_irq_pkg::ADDR_TEST_CTRL;
  wire logic c_wr = i_reg_wr && i_reg_addr == node_irq_pkg::ADDR_ERR_TALLY;
  wire logic p_rd = i_reg_rd && i_reg_addr == node_irq_pkg::ADDR_PIN_PEND;
  wire logic m_rd = i_reg_rd && i_reg_addr == node_irq_pkg::ADDR_MASTER_PEND;

  // Register stage plus output stage: controls follow a write two edges on
  property p_dir;
    t_wr |=> ##1 {o_prbs_down, o_prbs_up} == $past(i_reg_wdata[1:0], 2);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction enables differ from write");
  property p_hold;
    !t_wr && !$past(t_wr) |=> $stable({o_prbs_down, o_prbs_up, o_fifo_extra});
  endproperty
  a_hold: assert property (p_hold)
    else $error("test controls moved without a write");
  property p_fifo;
    t_wr && i_reg_wdata[5:4] == 2'h3 |=> ##1 o_fifo_extra == 2'h2;
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("fifo code 3 not two entries");
  property p_hop; o_hop_check |-> o_prbs_down || o_prbs_up; endproperty
  a_hop: assert property (p_hop)
    else $error("hop check without a direction");
  property p_clr; c_wr |=> !o_tally_overflow; endproperty
  a_clr: assert property (p_clr)
    else $error("overflow survived tally write");
  property p_pin0; i_is_master && p_rd |=> !o_reg_rdata[0]; endproperty
  a_pin0: assert property (p_pin0)
    else $error("pin 0 pending seen in master");
  property p_slv; !i_is_master && m_rd |=> o_reg_rdata == 8'h00; endproperty
  a_slv: assert property (p_slv)
    else $error("master pending nonzero in slave");
  property p_map;
    i_reg_rd && i_reg_addr > node_irq_pkg::ADDR_PRBS_B3 |=> o_reg_rdata == 8'h00;
  endproperty
  a_map: assert property (p_map)
    else $error("unmapped read not zero");
endmodule : node_irq_error_counting_checker

bind node_irq_error_counting node_irq_error_counting_checker #(
  .TALLY_W(TALLY_W), .PRBS_W(PRBS_W)
) u_checker (
  .i_clk, .i_reset, .i_is_master, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .o_tally_overflow, .o_prbs_down,
  .o_prbs_up, .o_hop_check, .o_fifo_extra
);

// File: node_irq_host.sv
`timescale 1ns/100ps
// Host on the register port; strobes rise and fall on falling edges
module node_irq_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // Idle bus; address is inverted after each access, write data after each write
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'h00;
  end

  // Test control writes stand for a broadcast to all nodes
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk) {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk) {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask : wr_reg

  // Read data lands on the sampling edge and is taken at the next falling edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk) {o_rd, o_addr} = {1'b1, a};
    @(negedge i_clk) {o_rd, o_addr} = {1'b0, ~a};
    d = i_rdata;
  endtask : rd_reg
endmodule : node_irq_host

// File: node_irq_error_counting_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %h seen %h", n, e, g); \
  end end
module node_irq_error_counting_test;
  // Bench signals; ev carries every one-cycle event strobe
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_is_master = 1'b1;
  logic [10:0] ev = 11'h000;
  logic [7:0]  lnk = 8'h00;
  logic        i_reg_wr, i_reg_rd, o_irq, o_tally_overflow;
  logic        o_prbs_down, o_prbs_up, o_hop_check;
  logic [1:0]  o_fifo_extra;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire  [4:0]  tst = {o_hop_check, o_fifo_extra, o_prbs_down, o_prbs_up};
  int          mismatches = 0, n_checks = 0, cycles = 0;

  node_irq_error_counting dut (
    .i_clk, .i_reset, .i_is_master, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_new_node(ev[0]), .i_i2c_fault(ev[1]),
    .i_irq_frame_crc(ev[2]), .i_slave_signal(ev[3]), .i_pin0_event(ev[4]),
    .i_pin1_event(ev[5]), .i_header_err(ev[6]), .i_decode_err(ev[7]),
    .i_frame_crc_err(ev[8]), .i_parity_err(ev[9]),
    .i_prbs_mismatch(ev[10]), .i_link_err_pending(lnk), .o_irq,
    .o_tally_overflow, .o_prbs_down, .o_prbs_up, .o_hop_check, .o_fifo_extra
  );
  node_irq_host host (.i_clk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));

  // Clock and a hang limit well above the roughly 730 cycles needed
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cycles == 20000) begin
    mismatches++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Role is a strap, so it only changes under reset
  task automatic do_reset(input logic m);
    @(negedge i_clk) {i_reset, i_is_master, lnk} = {1'b1, m, 8'h00};
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
  endtask : do_reset

  task automatic pulse(input logic [10:0] v);
    @(negedge i_clk) ev = v;
    @(negedge i_clk) ev = 11'h000;
  endtask : pulse

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask : chk_reg

  task automatic t_regs();
    do_reset(1'b1);
    for (int i = 0; i < 13; i++) chk_reg(8'(i), 8'h00);
    host.wr_reg(node_irq_pkg::ADDR_MASTER_MASK, 8'hff);
    chk_reg(node_irq_pkg::ADDR_MASTER_MASK, 8'h0f);
    host.wr_reg(node_irq_pkg::ADDR_TEST_CTRL, 8'hff);
    // Test controls sit one register stage behind the test register
    @(negedge i_clk);
    `CHK("tst", 5'h1b, tst)
    chk_reg(node_irq_pkg::ADDR_TEST_CTRL, 8'h37);
    host.wr_reg(node_irq_pkg::ADDR_TEST_CTRL, 8'h24);
    @(negedge i_clk);
    `CHK("tst", 5'h08, tst)
    host.wr_reg(node_irq_pkg::ADDR_PRBS_B0, 8'hff);
    host.wr_reg(8'h0c, 8'hff);
    chk_reg(node_irq_pkg::ADDR_PRBS_B0, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_events();
    do_reset(1'b1);
    pulse(11'h03f);
    chk_reg(node_irq_pkg::ADDR_PIN_PEND, 8'h02);
    chk_reg(node_irq_pkg::ADDR_MASTER_PEND, 8'h0f);
    `CHK("irq", 1'b0, o_irq)
    for (int k = 0; k < 4; k++) begin
      host.wr_reg(node_irq_pkg::ADDR_MASTER_MASK, 8'h01 << k);
      `CHK("irq", 1'b1, o_irq)
    end
    host.wr_reg(node_irq_pkg::ADDR_MASTER_PEND, 8'h07);
    `CHK("irq", 1'b1, o_irq)
    host.wr_reg(node_irq_pkg::ADDR_MASTER_PEND, 8'h08);
    `CHK("irq", 1'b0, o_irq)
    host.wr_reg(node_irq_pkg::ADDR_PIN_MASK, 8'h02);
    `CHK("irq", 1'b1, o_irq)
    host.wr_reg(node_irq_pkg::ADDR_PIN_PEND, 8'h02);
    `CHK("irq", 1'b0, o_irq)
    lnk = 8'h10;
    host.wr_reg(node_irq_pkg::ADDR_LINK_MASK, 8'h10);
    `CHK("irq", 1'b1, o_irq)
    do_reset(1'b0);
    pulse(11'h03f);
    chk_reg(node_irq_pkg::ADDR_PIN_PEND, 8'h03);
    chk_reg(node_irq_pkg::ADDR_MASTER_PEND, 8'h00);
    $display("t_events done");
  endtask : t_events

  // Each select alone; the other four sources must not count
  task automatic t_tally();
    logic [10:0] src [5] = '{11'h040, 11'h080, 11'h100, 11'h200, 11'h004};
    do_reset(1'b1);
    for (int k = 0; k < 5; k++) begin
      host.wr_reg(node_irq_pkg::ADDR_ERR_CTRL, 8'h01 << k);
      pulse(11'h3c4 & ~src[k]);
      pulse(src[k]);
      chk_reg(node_irq_pkg::ADDR_ERR_TALLY, 8'h01);
      host.wr_reg(node_irq_pkg::ADDR_ERR_TALLY, 8'h5a);
    end
    for (int n = 0; n < 7; n++) begin
      host.wr_reg(node_irq_pkg::ADDR_ERR_CTRL, {3'(n), 5'h01});
      host.wr_reg(node_irq_pkg::ADDR_ERR_TALLY, 8'h00);
      repeat ((2 << n) - 1) pulse(11'h040);
      `CHK("ovf", 1'b0, o_tally_overflow)
      pulse(11'h040);
      `CHK("ovf", 1'b1, o_tally_overflow)
      chk_reg(node_irq_pkg::ADDR_ERR_TALLY, 8'(2 << n));
    end
    $display("t_tally done");
  endtask : t_tally

  task automatic t_prbs();
    do_reset(1'b1);
    pulse(11'h400);
    host.wr_reg(node_irq_pkg::ADDR_TEST_CTRL, 8'h01);
    repeat (3) pulse(11'h400);
    for (int b = 0; b < 4; b++)
      chk_reg(node_irq_pkg::ADDR_PRBS_B0 + 8'(b), b == 0 ? 8'h03 : 8'h00);
    $display("t_prbs done");
  endtask : t_prbs

  // Main sequence
  initial begin
    t_regs();
    t_events();
    t_tally();
    t_prbs();
    stop_test();
  end
endmodule : node_irq_error_counting_test
